// file: hw/sspp_port.sv
// What this block does
// - active only when interface type selects SPI, except the irq pin, which follows requests under any type
// - timing mode, select and interrupt polarity configurable
// - five pins: clock, data in/out, select, irq
// - address phase of two bytes, or three or more with extension
// - zero or more data bytes, address increments
// - one bit each way per serial clock
// - launch and sample edges follow mode settings
// - most significant bit first, low byte first
// - two-byte mode forces upper address bits zero
// - three-byte mode uses all sixteen address bits
// - bytes 0/1 carry address and first command
// - byte 2 carries upper address, second command
// - decode nop, read, write, extension, read-wait
// - second command accepts same codes as first
// - repeated extension bytes accepted in address phase
// - address phase shifts out interrupt request bytes
// - low data-in during read byte prefetches next
// - partial byte flags error, counts, is not written
`include "sspp_consts.svh"
`default_nettype none

module sspp_port
  import sspp_pkg::*;
#(
  parameter int ERR_CNT_W = 8
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic [7:0] pdi_type_i,
  input wire logic [7:0] spi_cfg_i,
  // serial pins
  input wire logic spi_sck_i,
  input wire logic serial_data_in_i,
  input wire logic spi_sel_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic spi_irq_o,
  // interrupt request bytes shown during the address phase
  input wire logic [`SSPP_IRQ_W-1:0] irq_req_i,
  // internal memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [`SSPP_ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_rvalid_i,
  input wire logic [7:0] mem_rdata_i,
  // access status
  output logic access_err_o,
  output logic [ERR_CNT_W-1:0] err_cnt_o
);

  initial begin
    if (ERR_CNT_W < 1 || ERR_CNT_W > 32) begin
      $error("sspp_port: error counter width out of range");
    end
  end

  // ---------------------------------------------------------------
  // clock edges and framing derived from the configuration
  // ---------------------------------------------------------------
  logic cpha;
  logic cpol;
  logic late;
  logic sel_active;
  logic frame_rst;
  logic samp_clk;
  logic launch_clk;

  assign cpha = spi_cfg_i[`SSPP_CFG_CPHA];
  assign cpol = spi_cfg_i[`SSPP_CFG_CPOL];
  assign late = spi_cfg_i[`SSPP_CFG_LATE];
  // select polarity follows configuration
  assign sel_active = spi_sel_i ~^ spi_cfg_i[`SSPP_CFG_SEL_HIGH];
  // any deselect clears the link shifters
  assign frame_rst = rst_i | ~sel_active;
  // sample edge from clock polarity and phase
  assign samp_clk = spi_sck_i ^ cpol ^ cpha;
  // normal mode launches half a cycle after sampling, late on it
  assign launch_clk = late ? samp_clk : ~samp_clk;

  // ---------------------------------------------------------------
  // link sample domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [6:0] rx;
    sspp_phase_t phase;
    logic [2:0] cmd;
    logic ws_pending;
    logic [15:0] addr;
  } sspp_samp_t;

  sspp_samp_t sa_reg;
  sspp_samp_t sa_next;
  logic bad_reg;
  logic bad_next;
  // request toggle and fields kept apart: they outlive the frame
  logic req_tgl_reg;
  logic req_tgl_next;
  sspp_req_t req_reg;
  sspp_req_t req_next;
  logic [7:0] rx_byte;
  logic is_read;

  assign rx_byte = {sa_reg.rx, serial_data_in_i};
  assign is_read = (sa_reg.cmd == `SSPP_CMD_READ) ||
                   (sa_reg.cmd == `SSPP_CMD_READ_WS);

  always_comb begin
    sa_next = sa_reg;
    bad_next = 1'b0;
    req_tgl_next = req_tgl_reg;
    req_next = req_reg;
    // one bit in per sample edge, msb first
    sa_next.rx = rx_byte[6:0];
    sa_next.bitcnt = sa_reg.bitcnt + 3'h1;
    if (sa_reg.bitcnt == 3'h7) begin
      unique case (sa_reg.phase)
        SSPP_ADDR0: begin
          // byte 0: address bits 12..5, upper bits zero
          sa_next.addr = {3'h0, rx_byte, 5'h00};
          sa_next.phase = SSPP_ADDR1;
        end
        SSPP_ADDR1: begin
          // byte 1: address bits 4..0 and first command
          sa_next.addr[4:0] = rx_byte[7:3];
          sa_next.cmd = rx_byte[2:0];
          if (rx_byte[2:0] == `SSPP_CMD_EXT) begin
            sa_next.phase = SSPP_ADDR2;
          end else begin
            sa_next.phase = SSPP_DATA;
          end
        end
        SSPP_ADDR2: begin
          // upper address and second command, repeatable
          sa_next.addr[15:13] = rx_byte[7:5];
          sa_next.cmd = rx_byte[4:2];
          if (rx_byte[4:2] != `SSPP_CMD_EXT) begin
            sa_next.phase = SSPP_DATA;
          end
        end
        SSPP_DATA: begin
          if (sa_reg.cmd == `SSPP_CMD_WRITE) begin
            // each write byte goes to the memory side
            req_next = '{we: 1'b1, addr: sa_reg.addr, wdata: rx_byte};
            req_tgl_next = ~req_tgl_reg;
            sa_next.addr = sa_reg.addr + 16'h0001;
          end else if (is_read && sa_reg.ws_pending) begin
            // wait-state byte: address stays put
            sa_next.ws_pending = 1'b0;
          end else if (is_read) begin
            sa_next.addr = sa_reg.addr + 16'h0001;
            if (rx_byte != `SSPP_BYTE_ONES) begin
              // data-in low during the byte: prefetch next
              req_next = '{we: 1'b0, addr: sa_reg.addr + 16'h0001,
                           wdata: 8'h00};
              req_tgl_next = ~req_tgl_reg;
            end
          end
          // nop and reserved codes do nothing
        end
      endcase
      // read start fetches the first byte once the address is complete
      if (sa_reg.phase != SSPP_DATA && sa_next.phase == SSPP_DATA &&
          (sa_next.cmd == `SSPP_CMD_READ ||
           sa_next.cmd == `SSPP_CMD_READ_WS)) begin
        req_next = '{we: 1'b0, addr: sa_next.addr, wdata: 8'h00};
        req_tgl_next = ~req_tgl_reg;
        sa_next.ws_pending = (sa_next.cmd == `SSPP_CMD_READ_WS);
      end
    end
    // incomplete byte, or a read data byte not ending in all ones
    if (sa_reg.bitcnt != 3'h7) begin
      bad_next = 1'b1;
    end else if (sa_reg.phase == SSPP_DATA && is_read &&
                 !sa_reg.ws_pending && rx_byte != `SSPP_BYTE_ONES) begin
      bad_next = 1'b1;
    end
  end

  always_ff @(posedge samp_clk or posedge frame_rst) begin
    if (frame_rst) begin
      sa_reg.bitcnt <= 3'h0;
      sa_reg.rx <= 7'h00;
      sa_reg.phase <= SSPP_ADDR0;
      sa_reg.cmd <= `SSPP_CMD_NOP;
      sa_reg.ws_pending <= 1'b0;
      sa_reg.addr <= 16'h0000;
    end else begin
      sa_reg.bitcnt <= sa_next.bitcnt;
      sa_reg.rx <= sa_next.rx;
      sa_reg.phase <= sa_next.phase;
      sa_reg.cmd <= sa_next.cmd;
      sa_reg.ws_pending <= sa_next.ws_pending;
      sa_reg.addr <= sa_next.addr;
    end
  end

  // request toggle and fields outlive the frame for the crossing
  always_ff @(posedge samp_clk or posedge rst_i) begin
    if (rst_i) begin
      req_tgl_reg <= 1'b0;
      req_reg <= '0;
      bad_reg <= 1'b0;
    end else begin
      req_tgl_reg <= req_tgl_next;
      req_reg <= req_next;
      bad_reg <= bad_next;
    end
  end

  // ---------------------------------------------------------------
  // link launch domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] tx;
    logic miso;
  } sspp_launch_t;

  sspp_launch_t la_reg;
  sspp_launch_t la_next;
  logic [7:0] rdata_reg;
  logic [7:0] load_byte;

  always_comb begin
    la_next = la_reg;
    // interrupt request bytes, low byte first, during address
    unique case (la_reg.bytecnt)
      2'h0: load_byte = irq_req_i[7:0];
      2'h1: load_byte = irq_req_i[15:8];
      default: load_byte = irq_req_i[23:16];
    endcase
    if (sa_reg.phase == SSPP_DATA && is_read && !sa_reg.ws_pending) begin
      load_byte = rdata_reg;
    end
    la_next.bitcnt = la_reg.bitcnt + 3'h1;
    if (la_reg.bitcnt == 3'h0) begin
      la_next.miso = load_byte[7];
      la_next.tx = {load_byte[6:0], 1'b0};
    end else begin
      la_next.miso = la_reg.tx[7];
      la_next.tx = {la_reg.tx[6:0], 1'b0};
    end
    if (la_reg.bitcnt == 3'h7 && la_reg.bytecnt != 2'h3) begin
      la_next.bytecnt = la_reg.bytecnt + 2'h1;
    end
  end

  always_ff @(posedge launch_clk or posedge frame_rst) begin
    if (frame_rst) begin
      la_reg <= '0;
    end else begin
      la_reg <= la_next;
    end
  end

  assign spi_miso_o = la_reg.miso;

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------
  logic [2:0] sync_out;
  logic sel_s;
  logic tgl_s;
  logic bad_s;

  sspp_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({sel_active, req_tgl_reg, bad_reg}),
    .sync_o(sync_out)
  );

  assign sel_s = sync_out[2];
  assign tgl_s = sync_out[1];
  assign bad_s = sync_out[0];

  typedef struct packed {
    logic tgl_seen;
    logic sel_seen;
    logic mem_req;
    sspp_req_t req;
    logic [7:0] rdata;
    logic err;
    logic [ERR_CNT_W-1:0] err_cnt;
    logic irq;
    logic miso_oe;
  } sspp_sys_t;

  sspp_sys_t sy_reg;
  sspp_sys_t sy_next;
  logic enabled;

  // the port answers only when selected as the host interface
  assign enabled = (pdi_type_i == `SSPP_PDI_TYPE_SPI);

  always_comb begin
    sy_next = sy_reg;
    sy_next.mem_req = 1'b0;
    sy_next.err = 1'b0;
    sy_next.tgl_seen = tgl_s;
    sy_next.sel_seen = sel_s;
    if (tgl_s != sy_reg.tgl_seen && enabled) begin
      sy_next.mem_req = 1'b1;
      sy_next.req = req_reg;
    end
    if (mem_rvalid_i) begin
      sy_next.rdata = mem_rdata_i;
    end
    // frame end with a bad last edge: error pulse and count
    if (sy_reg.sel_seen && !sel_s && bad_s && enabled) begin
      sy_next.err = 1'b1;
      sy_next.err_cnt = sy_reg.err_cnt + {{(ERR_CNT_W-1){1'b0}}, 1'b1};
    end
    // interrupt polarity follows configuration
    sy_next.irq = (|irq_req_i) ^ ~spi_cfg_i[`SSPP_CFG_IRQ_HIGH];
    sy_next.miso_oe = sel_s & enabled;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy_reg <= '0;
      sy_reg.irq <= 1'b1;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign rdata_reg = sy_reg.rdata;
  assign mem_req_o = sy_reg.mem_req;
  assign mem_we_o = sy_reg.req.we;
  assign mem_addr_o = sy_reg.req.addr;
  assign mem_wdata_o = sy_reg.req.wdata;
  assign access_err_o = sy_reg.err;
  assign err_cnt_o = sy_reg.err_cnt;
  assign spi_irq_o = sy_reg.irq;
  assign spi_miso_oe_o = sy_reg.miso_oe;

endmodule

`default_nettype wire

// file: inc/sspp_consts.svh
`ifndef SSPP_CONSTS_SVH
`define SSPP_CONSTS_SVH

// host interface type that selects this serial port
`define SSPP_PDI_TYPE_SPI 8'h05

// configuration byte fields
`define SSPP_CFG_CPHA 0
`define SSPP_CFG_CPOL 1
`define SSPP_CFG_LATE 2
`define SSPP_CFG_SEL_HIGH 3
`define SSPP_CFG_IRQ_HIGH 4

// three-bit command codes
`define SSPP_CMD_NOP 3'h0
`define SSPP_CMD_READ 3'h2
`define SSPP_CMD_WRITE 3'h4
`define SSPP_CMD_EXT 3'h6
`define SSPP_CMD_READ_WS 3'h3

// termination / wait-state byte value
`define SSPP_BYTE_ONES 8'hff

// address and interrupt request widths
`define SSPP_ADDR_W 16
`define SSPP_IRQ_W 24

`endif

// file: inc/sspp_pkg.sv
`default_nettype none

package sspp_pkg;

  // byte position within the address phase, gray along the extension path
  typedef enum logic [1:0] {
    SSPP_ADDR0 = 2'h0,
    SSPP_ADDR1 = 2'h1,
    SSPP_ADDR2 = 2'h3,
    SSPP_DATA = 2'h2
  } sspp_phase_t;

  // one memory access handed from the link to the system side
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sspp_req_t;

endpackage

`default_nettype wire

// file: hw/sspp_sync.sv
`default_nettype none

module sspp_sync
  import sspp_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous levels in, settled levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  initial begin
    if (W < 1) begin
      $error("sspp_sync: width must be at least one");
    end
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } sspp_sync_t;

  sspp_sync_t st_reg;
  sspp_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      // a change counts once the second and third stage agree
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.out[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.out;

endmodule

`default_nettype wire

// file: dv/sspp_port_properties.sv
`include "sspp_consts.svh"
`default_nettype none

module sspp_port_properties
  import sspp_pkg::*;
#(
  parameter int ERR_CNT_W = 8
) (
  // clock, reset, configuration
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pdi_type_i,
  input wire logic [7:0] spi_cfg_i,
  // serial pins
  input wire logic spi_sck_i,
  input wire logic serial_data_in_i,
  input wire logic spi_sel_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic spi_irq_o,
  input wire logic [`SSPP_IRQ_W-1:0] irq_req_i,
  // memory port and status
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [`SSPP_ADDR_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_rvalid_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic access_err_o,
  input wire logic [ERR_CNT_W-1:0] err_cnt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic idle;
  assign idle = spi_sel_i != spi_cfg_i[`SSPP_CFG_SEL_HIGH] ||
                pdi_type_i != `SSPP_PDI_TYPE_SPI;

  chk_req_pulse: assert property (mem_req_o |=> !mem_req_o)
    else $error("memory request longer than one cycle");
  chk_fields_stand: assert property (
    !mem_req_o |-> $stable({mem_we_o, mem_addr_o, mem_wdata_o}))
    else $error("access fields moved without a request");
  chk_err_pulse: assert property (access_err_o |=> !access_err_o)
    else $error("error pulse longer than one cycle");
  chk_cnt_step: assert property (
    $changed(err_cnt_o) |-> err_cnt_o == $past(err_cnt_o) + 1'b1)
    else $error("error counter did not step by one");
  chk_cnt_cause: assert property (
    $changed(err_cnt_o) |-> access_err_o || $past(access_err_o))
    else $error("error counter moved without an error");
  chk_off_quiet: assert property (
    (pdi_type_i != `SSPP_PDI_TYPE_SPI)[*8] |-> !mem_req_o && !access_err_o)
    else $error("activity while another interface type is set");
  chk_oe_idle: assert property (idle[*6] |-> !spi_miso_oe_o)
    else $error("data out driven while not selected");
  chk_irq_level: assert property (
    $stable({irq_req_i, spi_cfg_i})[*3] |->
      spi_irq_o == ((|irq_req_i) == spi_cfg_i[`SSPP_CFG_IRQ_HIGH]))
    else $error("interrupt pin level wrong");
  chk_rst_vals: assert property (disable iff (1'b0)
    rst_i |=> !mem_req_o && !access_err_o && err_cnt_o == '0 &&
      spi_irq_o && !spi_miso_oe_o)
    else $error("outputs not at reset values");
endmodule

bind sspp_port sspp_port_properties #(.ERR_CNT_W(ERR_CNT_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .pdi_type_i(pdi_type_i),
  .spi_cfg_i(spi_cfg_i), .spi_sck_i(spi_sck_i),
  .serial_data_in_i(serial_data_in_i), .spi_sel_i(spi_sel_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .spi_irq_o(spi_irq_o), .irq_req_i(irq_req_i), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
  .access_err_o(access_err_o), .err_cnt_o(err_cnt_o));

`default_nettype wire

// file: dv/sspp_master.sv
`default_nettype none

module sspp_master (
  // serial pins toward the port
  output logic sck_o,
  output logic mosi_o,
  output logic sel_n_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    sel_n_o = 1'b1;
  end

  // phase 1: launch on leading, sample on trailing; clock still outside frames
  task automatic frame(input logic [63:0] tx, input int nbits,
                       input logic pol, output logic [63:0] rx);
    int k;
    rx = '0;
    // settle the idle level of this polarity before selecting
    sck_o = pol;
    #100;
    sel_n_o = 1'b0;
    // data out is enabled only after the select has crossed over
    #700;
    for (int i = 0; i < nbits; i++) begin
      k = (i / 8) * 8 + 7 - i % 8;
      sck_o = ~pol;
      mosi_o = tx[k];
      #24;
      sck_o = pol;
      rx[k] = miso_i;
      #24;
      // room for the prefetch to cross and return before the next byte
      if (i % 8 == 7) #900;
    end
    #100;
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #300;
  endtask
endmodule

`default_nettype wire

// file: dv/sspp_port_tb.sv
`include "sspp_consts.svh"
`default_nettype none

module sspp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sspp_pkg::*;
  logic clk_i, rst_i, sck, mosi, sel_n, miso, miso_q, miso_oe, irq;
  logic req, we, rvalid, aerr, sel_pin;
  logic [7:0] pdi_type, cfg, wdata, rdata, err_cnt;
  logic [15:0] addr;
  logic [23:0] irq_req;
  logic [63:0] rx;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h5, 3'h7};
  int fails, num_checks, errs;
  sspp_req_t got[$];

  assign miso = miso_oe ? miso_q : ~miso_q;
  // select pin level follows the configured polarity
  assign sel_pin = sel_n ^ cfg[`SSPP_CFG_SEL_HIGH];
  sspp_master u_m (.sck_o(sck), .mosi_o(mosi), .sel_n_o(sel_n),
    .miso_i(miso));
  sspp_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .pdi_type_i(pdi_type),
    .spi_cfg_i(cfg), .spi_sck_i(sck), .serial_data_in_i(mosi),
    .spi_sel_i(sel_pin), .spi_miso_o(miso_q), .spi_miso_oe_o(miso_oe),
    .spi_irq_o(irq), .irq_req_i(irq_req), .mem_req_o(req), .mem_we_o(we),
    .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_rvalid_i(rvalid),
    .mem_rdata_i(rdata), .access_err_o(aerr), .err_cnt_o(err_cnt));

  // memory answers reads with a pattern of the address
  always @(posedge clk_i) begin
    rvalid <= req && !we;
    rdata <= addr[7:0] ^ 8'h5a;
    if (req) got.push_back('{we, addr, wdata});
    if (aerr) errs++;
  end

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
      fails++;
    end
  endtask

  task automatic send(input logic [63:0] tx, input int nbits);
    got.delete();
    u_m.frame(tx, nbits, cfg[`SSPP_CFG_CPOL], rx);
    repeat (12) @(posedge clk_i);
  endtask

  task automatic t_write2();
    send(64'hcd_ab_24_00, 32);
    chk(got.size(), 2);
    chk(got[0], {1'b1, 16'h0004, 8'hab});
    chk(got[1], {1'b1, 16'h0005, 8'hcd});
    chk(rx[15:0], irq_req[15:0]);
  endtask

  task automatic t_write3();
    send(64'hee_b0_b8_1e_09, 40);
    chk(got.size(), 1);
    chk(got[0], {1'b1, 16'ha123, 8'hee});
    chk(rx[31:16], {2{irq_req[23:16]}});
  endtask

  task automatic t_read();
    int e;
    e = errs;
    send(64'hff_00_ff_43_00, 40);
    chk(got.size(), 2);
    chk(got[0][24:8], {1'b0, 16'h0008});
    chk(got[1][24:8], {1'b0, 16'h0009});
    chk(rx[39:24], 16'h53_52);
    chk(errs, e);
  endtask

  task automatic t_nop();
    for (int i = 0; i < 4; i++) begin
      send({40'h0, 8'h55, 5'h02, codes[i], 8'haa}, 24);
      chk(got.size(), 0);
    end
  endtask

  task automatic t_partial();
    int e;
    logic [7:0] c;
    e = errs;
    c = err_cnt;
    send(64'h55_24_00, 21);
    chk(got.size(), 0);
    chk(errs, e + 1);
    chk(err_cnt, c + 8'h01);
    t_write2();
  endtask

  // clock idle high, select and interrupt active high
  task automatic t_modes();
    cfg <= 8'h1b;
    repeat (8) @(posedge clk_i);
    chk(irq, 1'b1);
    t_write2();
    cfg <= 8'h01;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic t_off();
    pdi_type <= 8'h04;
    irq_req <= 24'h0;
    repeat (8) @(posedge clk_i);
    send(64'hab_24_00, 24);
    chk(got.size(), 0);
    chk(miso_oe, 1'b0);
    chk(irq, 1'b1);
    pdi_type <= 8'h05;
    irq_req <= 24'h3ca581;
    repeat (8) @(posedge clk_i);
    chk(irq, 1'b0);
  endtask

  task automatic stop_test();
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    #1000000;
    fails++;
    stop_test();
  end

  initial begin
    rst_i = 1'b1;
    pdi_type = 8'h05;
    cfg = 8'h01;
    irq_req = 24'h3ca581;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    t_write2();
    t_write3();
    t_read();
    t_nop();
    t_partial();
    t_modes();
    t_off();
    stop_test();
  end
endmodule

`default_nettype wire
